/* ipcc_ctrl.sv */
// idle power configuration control: idle entry, clock gating, wake
// assumes cpu pulses idleExec once per idle instruction; reset is the
// device hardware reset and clears all sleep state
`timescale 1ns/10ps
module ipcc_ctrl import ipcc_pkg::*; (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // idle instruction
   input wire logic idleExec,
   input wire logic idleParallel,
   input wire ipcc_idle_t idleConfigReg,
   // cpu interrupt flags and enables
   input wire ipcc_irq_t irqSet,
   input wire logic flagClrStb,
   input wire ipcc_irq_t flagClr,
   input wire ipcc_irq_t cpuIrqEnables,
   // rtc and wake pin
   input wire logic rtcEvent,
   input wire logic rtcIrqEnable,
   input wire logic wakePin,
   input wire logic wakePinDirection,
   // bus masters on the memory port
   input wire logic usbDmaActive,
   input wire logic lcdActive,
   input wire logic dmaActive,
   // clock generator state set by software
   input wire logic clkGenEnabled,
   // status
   output ipcc_idle_t idleStateReg,
   output ipcc_irq_t cpuIrqFlags,
   output logic lightSleepMode,
   output logic deepSleepMode,
   output logic wakeIrq,
   // clock enables and wake pin output enable
   output ipcc_idle_t unitClkEn,
   output logic periphClkEn,
   output logic usbClkEn,
   output logic clkGenClkEn,
   output logic rtcClkEn,
   output logic wakePinOe
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   ipcc_state_t s_q;
   ipcc_state_t s_d;
   ipcc_irq_t setNow;
   logic wake;
   logic portBusy;
   logic asleep;

   // one clock domain: every check below uses these
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   assign portBusy = usbDmaActive | lcdActive | dmaActive;
   assign asleep = (s_q.fsm == IPCC_SLEEP);

   // R05 rtc reaches its flag only when enabled
   always_comb begin
      setNow = irqSet;
      setNow.high[IPCC_RTC_BIT] = irqSet.high[IPCC_RTC_BIT] | (rtcEvent & rtcIrqEnable);
   end

   ipcc_wake_detect u_wake (
      .deep(s_q.deep),
      .flags(s_q.flags),
      .enables(cpuIrqEnables),
      .wakePin(wakePin),
      .wakePinDirection(wakePinDirection),
      .wake(wake)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.wakeIrq = 1'b0;
      // R03 write one clears, set wins
      if (flagClrStb) begin
         s_d.flags = s_q.flags & ~flagClr;
      end
      s_d.flags = s_d.flags | setNow;
      case (s_q.fsm)
         IPCC_ACTIVE: begin
            // R01 latch config; R02 paired issue ignored
            if (idleExec && !idleParallel) begin
               s_d.idle_state_reg = idleConfigReg;
               s_d.deep = ~clkGenEnabled;
               s_d.fsm = IPCC_ENTER;
            end
         end
         IPCC_ENTER: begin
            // R22 partial idle keeps cpu running
            if (s_q.idle_state_reg[IPCC_CPU_BIT]) begin
               s_d.fsm = IPCC_SLEEP;
            end else begin
               s_d.fsm = IPCC_ACTIVE;
               s_d.deep = 1'b0;
            end
         end
         IPCC_SLEEP: begin
            // R10 no relock or power-up wait
            if (wake) begin
               s_d.fsm = IPCC_WAKE;
               s_d.idle_state_reg = IPCC_IDLE_RST;
               s_d.wakeIrq = 1'b1;
            end
         end
         IPCC_WAKE: begin
            // R07 handler runs, then code resumes past the idle
            s_d.fsm = IPCC_ACTIVE;
            s_d.deep = 1'b0;
         end
         default: begin
            s_d.fsm = IPCC_ACTIVE;
         end
      endcase
   end

   // R08 reset discards all sleep state
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_q.fsm <= IPCC_ACTIVE;
         s_q.deep <= 1'b0;
         s_q.idle_state_reg <= IPCC_IDLE_RST;
         s_q.flags <= '{high: IPCC_FLAG_RST, low: IPCC_FLAG_RST};
         s_q.wakeIrq <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign idleStateReg = s_q.idle_state_reg;
   assign cpuIrqFlags = s_q.flags;
   assign wakeIrq = s_q.wakeIrq;
   assign lightSleepMode = asleep & ~s_q.deep;
   assign deepSleepMode = asleep & s_q.deep;

   // R22 one gate per unit
   genvar gi;
   generate
      for (gi = 0; gi < IPCC_IDLE_W; gi++) begin : g_gate
         if (gi == IPCC_MEMORY_ACCESS_PORT_BIT) begin : g_memory_access_port
            // R06 masters still need the memory port
            assign unitClkEn[gi] = ~s_q.idle_state_reg[gi] | portBusy;
         end else begin : g_unit
            // R01 idle state drives gating
            assign unitClkEn[gi] = ~s_q.idle_state_reg[gi];
         end
      end
   endgenerate

   // R09 light sleep keeps generator running
   // R11 deep sleep stops generator and usb
   assign periphClkEn = ~asleep;
   assign usbClkEn = ~deepSleepMode;
   assign clkGenClkEn = ~deepSleepMode;
   assign rtcClkEn = 1'b1;
   // R04 direction bit one makes the pin an input
   assign wakePinOe = ~wakePinDirection;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   chk_idle_state_reg_load: assert property ( // R01
      (s_q.fsm == IPCC_ACTIVE && idleExec && !idleParallel)
      |=> (idleStateReg == $past(idleConfigReg)) && (s_q.fsm == IPCC_ENTER))
      else $error("idle config not copied on idle");

   chk_paired_idle: assert property ( // R02
      (s_q.fsm == IPCC_ACTIVE && idleExec && idleParallel) |=> s_q.fsm == IPCC_ACTIVE)
      else $error("paired idle was taken");

   chk_flag_setwins: assert property ( // R03
      (flagClrStb && flagClr.low[0] && irqSet.low[0]) |=> cpuIrqFlags.low[0])
      else $error("flag set lost against clear");

   chk_flag_clear: assert property ( // R03
      (flagClrStb && flagClr.high[5] && !irqSet.high[5]) |=> !cpuIrqFlags.high[5])
      else $error("flag not cleared by write one");

   chk_pin_dir: assert property ( // R04
      wakePinDirection |-> !wakePinOe)
      else $error("wake pin driven while input");

   chk_memory_access_port_hold: assert property ( // R06
      portBusy |-> unitClkEn[IPCC_MEMORY_ACCESS_PORT_BIT])
      else $error("memory port idled while master busy");

   chk_wake_resume: assert property ( // R07
      (asleep && wake) |=> wakeIrq && (unitClkEn == IPCC_IDLE_ALL) ##1
      (s_q.fsm == IPCC_ACTIVE) && !wakeIrq)
      else $error("wake did not restart clocks");

   chk_light_run: assert property ( // R09
      lightSleepMode |-> clkGenClkEn && rtcClkEn && !periphClkEn)
      else $error("light sleep clock domains wrong");

   chk_deep_stop: assert property ( // R11
      deepSleepMode |-> !clkGenClkEn && !usbClkEn && !periphClkEn && rtcClkEn)
      else $error("deep sleep clock domains wrong");

   chk_deep_pin: assert property ( // R21
      (deepSleepMode && wakePin && wakePinDirection) |=> wakeIrq)
      else $error("deep sleep missed wake pin");

   chk_deep_mask: assert property ( // R21
      (deepSleepMode && !wakePin && ((cpuIrqFlags.low & cpuIrqEnables.low
      & IPCC_DEEP_MASK_LOW) == 16'h0000) && ((cpuIrqFlags.high
      & cpuIrqEnables.high & IPCC_DEEP_MASK_HIGH) == 16'h0000)) |=> !wakeIrq)
      else $error("deep sleep woke on a peripheral source");

   chk_partial_idle: assert property ( // R22
      (s_q.fsm == IPCC_ENTER && !idleStateReg[IPCC_CPU_BIT])
      |=> s_q.fsm == IPCC_ACTIVE && unitClkEn[IPCC_CPU_BIT])
      else $error("partial idle stopped the cpu");

   chk_light_any: assert property ( // R20
      (lightSleepMode && (|(cpuIrqFlags & cpuIrqEnables))) |=> wakeIrq)
      else $error("light sleep missed an enabled interrupt");

   chk_light_pin: assert property ( // R10
      (lightSleepMode && wakePin && wakePinDirection) |=> wakeIrq && !lightSleepMode)
      else $error("light sleep wake was delayed");

endmodule // ipcc_ctrl

/* ipcc_pkg.sv */
// idle power configuration control: shared constants and types
// assumes one 50 MHz cpu clock and an asynchronous active-high reset
// ----------------------------------------------------------------
// Overview of operation
// R01 - on idle instruction copy idle config into idle state, then gate clocks
// R02 - software issues the idle instruction alone, never paired
// R03 - writing one clears a pending flag; software clears all before sleeping
// R04 - wake pin direction bit set to one makes wake pin an input
// R05 - software sets rtc interrupt enable to wake on rtc events
// R06 - memory port stays awake while usb dma, lcd or dma is active
// R07 - wake restarts cpu clocks, runs handler, resumes after idle
// R08 - hardware reset during sleep fully resets, nothing kept
// R09 - light sleep keeps rtc and clock generator running, stops cpu, peripherals
// R10 - light sleep wake needs no power-up or pll relock wait
// R11 - deep sleep stops cpu, clock generator, peripherals, usb; rtc runs
// R12 - software waits for pll relock after deep sleep
// R13 - software re-enables clock generator after deep sleep wake
// R14 - software sets all six idle bits to stop the cpu domain
// R15 - software drains dma, stops usb, idles peripherals, in that order
// R16 - deep sleep only: software stops clock generator before clearing flags
// R17 - software enables wake interrupt; only enabled interrupts wake
// R18 - software lowers clock rate before lowering core voltage
// R19 - software waits for supply to settle after raising voltage
// R20 - light sleep also wakes on any unmasked peripheral interrupt
// R21 - deep sleep wakes on wake pin, rtc, external irq a or b, reset
// R22 - each idle state bit gates only its own unit clock
// ----------------------------------------------------------------
package ipcc_pkg;

   // --------------------------------------------------------------
   // idle bit positions
   // --------------------------------------------------------------
   localparam int IPCC_IDLE_W = 6;
   localparam int IPCC_CPU_BIT = 0;
   localparam int IPCC_MEMORY_ACCESS_PORT_BIT = 1;
   localparam int IPCC_XPORT_BIT = 2;
   localparam int IPCC_DPORT_BIT = 3;
   localparam int IPCC_IPORT_BIT = 4;
   localparam int IPCC_COP_BIT = 5;
   localparam logic [5:0] IPCC_IDLE_RST = 6'h00;
   localparam logic [5:0] IPCC_IDLE_ALL = 6'h3f;

   // --------------------------------------------------------------
   // interrupt flag layout
   // --------------------------------------------------------------
   localparam int IPCC_FLAG_W = 16;
   localparam int IPCC_EXT_A_BIT = 2;
   localparam int IPCC_EXT_B_BIT = 3;
   localparam int IPCC_RTC_BIT = 2;
   localparam logic [15:0] IPCC_FLAG_RST = 16'h0000;
   localparam logic [15:0] IPCC_DEEP_MASK_LOW = 16'h000c;
   localparam logic [15:0] IPCC_DEEP_MASK_HIGH = 16'h0004;

   typedef logic [IPCC_IDLE_W-1:0] ipcc_idle_t;

   typedef struct packed {
      logic [IPCC_FLAG_W-1:0] high;
      logic [IPCC_FLAG_W-1:0] low;
   } ipcc_irq_t;

   // gray order along active, enter, sleep, wake
   typedef enum logic [1:0] {
      IPCC_ACTIVE = 2'h0,
      IPCC_ENTER = 2'h1,
      IPCC_SLEEP = 2'h3,
      IPCC_WAKE = 2'h2
   } ipcc_fsm_t;

   typedef struct packed {
      ipcc_fsm_t fsm;
      logic deep;
      ipcc_idle_t idle_state_reg;
      ipcc_irq_t flags;
      logic wakeIrq;
   } ipcc_state_t;

endpackage

/* ipcc_wake_detect.sv */
// idle power configuration control: wake source qualification
// assumes flags and enables are already registered in the cpu domain
`timescale 1ns/10ps
module ipcc_wake_detect import ipcc_pkg::*; (
   // mode
   input wire logic deep,
   // sources
   input wire ipcc_irq_t flags,
   input wire ipcc_irq_t enables,
   input wire logic wakePin,
   input wire logic wakePinDirection,
   // result
   output logic wake
);
   ipcc_irq_t live;
   logic pinWake;
   logic deepWake;
   logic lightWake;

   // R17 only enabled
   assign live = flags & enables;
   // R04 pin must be input
   assign pinWake = wakePin & wakePinDirection;
   // R21 deep sources
   assign deepWake = pinWake | (|(live.low & IPCC_DEEP_MASK_LOW))
      | (|(live.high & IPCC_DEEP_MASK_HIGH));
   // R20 any unmasked source
   assign lightWake = pinWake | (|live);
   assign wake = deep ? deepWake : lightWake;
endmodule // ipcc_wake_detect

/* ipcc_wake_src.sv */
// wake source model: wake pin level, rtc event and interrupt set pulses
// assumes one bench process calls its tasks, right after a clock edge
`timescale 1ns/10ps
module ipcc_wake_src import ipcc_pkg::*; (
   // clock
   input wire logic clock,
   // wake sources
   output logic wakePin,
   output logic rtcEvent,
   output ipcc_irq_t irqSet
);
   initial begin
      wakePin = 1'b0;
      rtcEvent = 1'b0;
      irqSet = '0;
   end
   task automatic pulse(input logic [31:0] v, input logic rtc);
      @(posedge clock);
      irqSet <= v;
      rtcEvent <= rtc;
      @(posedge clock);
      irqSet <= '0;
      rtcEvent <= 1'b0;
   endtask
   // pin is a level, low when idle
   task pin(input logic v);
      @(posedge clock);
      wakePin <= v;
   endtask
endmodule // ipcc_wake_src

/* tb.sv */
// testbench for ipcc_ctrl: idle entry, sleep modes, wake sources, flags
// assumes the ipcc_pkg layout: ext irq a/b at low bits 2/3, rtc at high bit 2
`timescale 1ns/10ps
module tb import ipcc_pkg::*;;
   logic clock, rst = 1'b1, idleExec = 1'b0, idleParallel = 1'b0, flagClrStb = 1'b0;
   logic rtcIrqEnable = 1'b1, wakePinDirection = 1'b0, clkGenEnabled = 1'b1;
   logic usbDmaActive = 1'b0, lcdActive = 1'b0, dmaActive = 1'b0, rtcEvent, wakePin;
   ipcc_idle_t idleConfigReg = '0, idleStateReg, unitClkEn, cfg;
   ipcc_irq_t flagClr = '0, cpuIrqEnables = '0, irqSet, cpuIrqFlags;
   logic lightSleepMode, deepSleepMode, wakeIrq, periphClkEn, usbClkEn, clkGenClkEn;
   logic rtcClkEn, wakePinOe;
   logic [2:0] busy;
   logic [31:0] expFlags = '0;
   int n_fail = 0, n_compared = 0, cycles = 0;
   integer seed = 32'hb7ab;
   // relock time is not modelled; a few cycles stand for it
   localparam int RELOCK_WAIT = 8;

   ipcc_ctrl ipcc_ctrl_i (.clock(clock), .rst(rst), .idleExec(idleExec),
      .idleParallel(idleParallel), .idleConfigReg(idleConfigReg), .irqSet(irqSet),
      .flagClrStb(flagClrStb), .flagClr(flagClr), .cpuIrqEnables(cpuIrqEnables),
      .rtcEvent(rtcEvent), .rtcIrqEnable(rtcIrqEnable), .wakePin(wakePin),
      .wakePinDirection(wakePinDirection), .usbDmaActive(usbDmaActive),
      .lcdActive(lcdActive), .dmaActive(dmaActive), .clkGenEnabled(clkGenEnabled),
      .idleStateReg(idleStateReg), .cpuIrqFlags(cpuIrqFlags),
      .lightSleepMode(lightSleepMode), .deepSleepMode(deepSleepMode), .wakeIrq(wakeIrq),
      .unitClkEn(unitClkEn), .periphClkEn(periphClkEn), .usbClkEn(usbClkEn),
      .clkGenClkEn(clkGenClkEn), .rtcClkEn(rtcClkEn), .wakePinOe(wakePinOe));
   ipcc_wake_src ipcc_wake_src_i (.clock(clock), .wakePin(wakePin), .rtcEvent(rtcEvent),
      .irqSet(irqSet));

   // --------------------------------------------------------------
   // bench tasks
   // --------------------------------------------------------------
   task end_sim();
      $display("mismatches %0d, compares %0d", n_fail, n_compared);
      if (n_fail == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task cmp(input logic [63:0] got, input logic [63:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task idle(input ipcc_idle_t c, input logic par, input logic light);
      @(posedge clock);
      idleConfigReg <= c;
      idleExec <= 1'b1;
      idleParallel <= par;
      clkGenEnabled <= light;
      @(posedge clock);
      idleExec <= 1'b0;
      #1;
   endtask
   // flag model: set wins, rtc only counts while enabled
   task fire(input logic [31:0] v, input logic rtc);
      ipcc_wake_src_i.pulse(v, rtc);
      expFlags |= v | ((rtc && rtcIrqEnable) ? 32'h0004_0000 : 32'h0);
      #1;
      cmp({wakeIrq, cpuIrqFlags}, {1'b0, expFlags}, "flags set");
   endtask
   task clr(input logic [31:0] v, input logic [31:0] s);
      fork
         ipcc_wake_src_i.pulse(s, 1'b0);
         begin
            @(posedge clock);
            flagClr <= v;
            flagClrStb <= 1'b1;
            @(posedge clock);
            flagClrStb <= 1'b0;
         end
      join
      // set and clear on one edge: set wins
      expFlags = (expFlags & ~v) | s;
      #1;
      cmp(cpuIrqFlags, expFlags, "flags clear");
   endtask
   task waitWake();
      for (int i = 0; i < 4 && wakeIrq !== 1'b1; i++) begin
         @(posedge clock);
         #1;
      end
      cmp({wakeIrq, idleStateReg, unitClkEn, lightSleepMode, deepSleepMode},
          {1'b1, 6'h00, 6'h3f, 2'b00}, "wake");
      @(posedge clock);
      #1;
      cmp(wakeIrq, 1'b0, "wake pulse");
   endtask

   // one fixed rate and supply: no voltage step to order
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail++;
         end_sim();
      end
   end

   // --------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      #1;
      cmp({idleStateReg, unitClkEn, periphClkEn, usbClkEn, clkGenClkEn, rtcClkEn, wakePinOe},
          {6'h00, 6'h3f, 5'h1f}, "reset state");
      @(posedge clock);
      wakePinDirection <= 1'b1;
      cpuIrqEnables <= 32'h0004_010c;
      #1;
      cmp(wakePinOe, 1'b0, "pin input");
      for (int i = 0; i < 6; i++) begin
         // memory port always idled so the busy override is seen
         cfg = (6'($random(seed)) & 6'h3e) | 6'h02;
         busy = 3'($random(seed));
         @(posedge clock);
         {usbDmaActive, lcdActive, dmaActive} <= busy;
         rtcIrqEnable <= i[0];
         idle(cfg, 1'b0, 1'b1);
         cmp({idleStateReg, unitClkEn}, {cfg, ~cfg | ((busy != 0) ? 6'h02 : 6'h00)},
             "partial idle");
         idle(~cfg, 1'b1, 1'b1);
         cmp(idleStateReg, cfg, "paired idle");
         fire(32'($random(seed)), 1'b1);
         // bit 0 set and cleared on one edge
         clr(32'($random(seed)) | 32'h1, 32'($random(seed)) | 32'h1);
      end
      @(posedge clock);
      {usbDmaActive, lcdActive, dmaActive} <= 3'h0;
      rtcIrqEnable <= 1'b1;
      // k: 0 pin, 1 ext a, 2 ext b, 3 rtc, 4 peripheral
      for (int m = 0; m < 2; m++) begin
         for (int k = 0; k < 5; k++) begin
            @(posedge clock);
            clkGenEnabled <= (m == 0);
            clr(32'hffff_ffff, 32'h0);
            idle(IPCC_IDLE_ALL, 1'b0, m == 0);
            @(posedge clock);
            #1;
            cmp({lightSleepMode, deepSleepMode, periphClkEn, usbClkEn, clkGenClkEn, rtcClkEn,
                 unitClkEn}, {m == 0, m == 1, 1'b0, m == 0, m == 0, 1'b1, 6'h00},
                "sleep clocks");
            if (k == 0) begin
               ipcc_wake_src_i.pin(1'b1);
               #1;
            end else
               fire((k == 1) ? 32'h4 : (k == 2) ? 32'h8 : (k == 4) ? 32'h100 : 32'h0,
                    k == 3);
            if (m == 1 && k == 4) begin
               repeat (4) @(posedge clock);
               #1;
               cmp({deepSleepMode, wakeIrq}, 2'b10, "no deep wake");
               ipcc_wake_src_i.pin(1'b1);
               #1;
            end
            waitWake();
            ipcc_wake_src_i.pin(1'b0);
            if (m == 1) begin
               // relock wait, then clock generator back on
               repeat (RELOCK_WAIT) @(posedge clock);
               clkGenEnabled <= 1'b1;
            end
         end
      end
      @(posedge clock);
      clkGenEnabled <= 1'b0;
      clr(32'hffff_ffff, 32'h0);
      idle(IPCC_IDLE_ALL, 1'b0, 1'b0);
      fire(32'h100, 1'b0);
      cmp(deepSleepMode, 1'b1, "deep before reset");
      @(posedge clock);
      rst <= 1'b1;
      expFlags = '0;
      @(posedge clock);
      #1;
      cmp({idleStateReg, cpuIrqFlags, deepSleepMode, unitClkEn, wakeIrq},
          {6'h00, 32'h0, 1'b0, 6'h3f, 1'b0}, "reset in sleep");
      @(posedge clock);
      rst <= 1'b0;
      idle(6'h3e, 1'b0, 1'b1);
      cmp({idleStateReg, unitClkEn}, {6'h3e, 6'h01}, "idle after reset");
      end_sim();
   end
endmodule // tb
